// [rtl/tpg_cfg.svh]
// Offsets, field positions, reset values and timing figures of the packet generator
`ifndef TPG_CFG_SVH
`define TPG_CFG_SVH
// ==========
// Register map
`define TPG_ADDR_CTRL 5'h1d
`define TPG_ADDR_PAY 5'h1e
`define TPG_ADDR_CRC 5'h17
`define TPG_CTRL_RST 16'h0040
`define TPG_PAY_RST 16'h0000
// ==========
// Control fields
`define TPG_B_EN 15
`define TPG_B_RUN 14
`define TPG_B_CONT 13
`define TPG_B_LEN_H 12
`define TPG_B_LEN_L 11
`define TPG_B_GAP 10
`define TPG_B_DA_H 9
`define TPG_B_DA_L 6
`define TPG_B_SA_H 5
`define TPG_B_SA_L 2
`define TPG_B_RAND 1
`define TPG_B_BADFCS 0
// ==========
// Frame shape
`define TPG_LEN_00 14'd125
`define TPG_LEN_01 14'd64
`define TPG_LEN_10 14'd1518
`define TPG_LEN_11 14'd10000
`define TPG_HDR_BYTES 14'd14
`define TPG_OVH_BYTES 14'd18
`define TPG_CRC_INIT 32'hffffffff
`define TPG_CRC_POLY 32'hedb88320
`define TPG_LFSR_SEED 16'hace1
`define TPG_CNT_MAX 8'hff
// ==========
// Timing and counts
`define TPG_CLK_MHZ 100
`define TPG_IPG_SHORT_NS 96
`define TPG_IPG_LONG_NS 8192
`define TPG_BLOCK_PKTS 10000
`define TPG_RUN_PKTS 30000000
`define TPG_FIFO_DEPTH 8
`endif

// [rtl/tpg_pkg.sv]
// Types shared by the packet generator
package tpg_pkg;
  typedef logic [7:0] tpg_byte_t;
  typedef logic [15:0] tpg_word_t;
  typedef logic [4:0] tpg_addr_t;
  typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_PAY, ST_FCS, ST_GAP} tpg_state_e;
endpackage

// [rtl/tpg_gen.sv]
// Test packet generator with its control registers, CRC error counter and output FIFO
// What this block does
// - Frames start only while enable bit 15 and run bit 14 are both one
// - Continuous mode sends endlessly, counted in blocks of 10,000 packets
// - Non-continuous run sends exactly 30,000,000 packets then stops
// - Continuous turned off mid-run stops at next 10,000-packet mark
// - Length field picks 125, 64, 1518 or 10,000 byte frames
// - Gap bit picks 8,192 ns or 96 ns idle between frames
// - Destination address is all ones, lowest nibble from bits 9:6, default 0001
// - Source address is all ones, lowest nibble from bits 5:2, default 0000
// - Payload bit picks random payload or fixed programmed pattern
// - Bit 0 appends a corrupted FCS, otherwise a correct one
// - Control changes other than clearing continuous, enable or run apply only after run is cleared and set again
// - Fixed payload repeats the 16-bit pattern register, default zero
// - New pattern applies only after run is cleared and set again
// - CRC error counter saturates at 0xff, read clears it, then counts again
`timescale 1ns/1ns
`default_nettype none
`include "tpg_cfg.svh"

// ==========
// FIFO
module tpg_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_reg != (AW+1)'(D));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem[rd_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(D-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(D-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==========
// Generator top
module tpg_gen #(
  parameter int unsigned BLOCK_PKTS = `TPG_BLOCK_PKTS,
  parameter int unsigned RUN_PKTS = `TPG_RUN_PKTS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire tpg_pkg::tpg_addr_t reg_addr_i,
  input wire tpg_pkg::tpg_word_t reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output tpg_pkg::tpg_word_t reg_rdata_o,
  // Receive side
  input wire logic rx_crc_err_i,
  // Transmit stream
  output tpg_pkg::tpg_byte_t tx_data_o,
  output logic tx_valid_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  // Status
  output logic busy_o
);
  import tpg_pkg::*;

  localparam int GAP_S = (`TPG_IPG_SHORT_NS * `TPG_CLK_MHZ + 999) / 1000;
  localparam int GAP_L = (`TPG_IPG_LONG_NS * `TPG_CLK_MHZ + 999) / 1000;

  tpg_word_t ctrl_reg;
  tpg_word_t pay_reg;
  tpg_word_t cfg_reg;
  tpg_word_t pat_reg;
  tpg_byte_t crcerr_reg;
  logic go_prev_reg;
  logic pend_reg;
  tpg_state_e state_reg;
  logic [13:0] bcnt_reg;
  logic [9:0] gap_reg;
  logic [13:0] blk_reg;
  logic [24:0] tot_reg;
  logic [31:0] crc_reg;
  logic [15:0] lfsr_reg;
  logic go;
  logic push;
  logic in_ready;
  logic fifo_valid;
  logic [8:0] fifo_data;
  logic take;
  logic frame_end;
  logic stop;
  logic [13:0] flen;
  logic [13:0] plen;
  logic [31:0] fcs;
  tpg_byte_t byte_cur;

  function automatic logic [31:0] crc_step(input logic [31:0] c, input tpg_byte_t b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ `TPG_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ==========
  // Registers
  assign go = ctrl_reg[`TPG_B_EN] && ctrl_reg[`TPG_B_RUN];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= `TPG_CTRL_RST;
      pay_reg <= `TPG_PAY_RST;
    end else if (reg_we_i) begin
      if (reg_addr_i == `TPG_ADDR_CTRL) begin
        ctrl_reg <= reg_wdata_i;
      end
      if (reg_addr_i == `TPG_ADDR_PAY) begin
        pay_reg <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_re_i) begin
      unique case (reg_addr_i)
        `TPG_ADDR_CTRL: reg_rdata_o <= ctrl_reg;
        `TPG_ADDR_PAY: reg_rdata_o <= pay_reg;
        `TPG_ADDR_CRC: reg_rdata_o <= {8'h00, crcerr_reg};
        default: reg_rdata_o <= '0;
      endcase
    end
  end

  // A read in the same cycle as an error keeps that error
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      crcerr_reg <= '0;
    end else if (reg_re_i && reg_addr_i == `TPG_ADDR_CRC) begin
      crcerr_reg <= {7'h00, rx_crc_err_i};
    end else if (rx_crc_err_i && crcerr_reg != `TPG_CNT_MAX) begin
      crcerr_reg <= crcerr_reg + 8'h01;
    end
  end

  // ==========
  // Run start
  // A restart asked mid-frame waits for the frame to finish, so no torn frame leaves
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      go_prev_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      go_prev_reg <= go;
      if (go && !go_prev_reg) begin
        pend_reg <= 1'b1;
      end else if (take || !go) begin
        pend_reg <= 1'b0;
      end
    end
  end

  assign take = pend_reg && go && (state_reg == ST_IDLE || state_reg == ST_GAP);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_reg <= `TPG_CTRL_RST;
      pat_reg <= `TPG_PAY_RST;
    end else if (take) begin
      cfg_reg <= ctrl_reg;
      pat_reg <= pay_reg;
    end
  end

  // ==========
  // Frame content
  always_comb begin
    unique case (cfg_reg[`TPG_B_LEN_H:`TPG_B_LEN_L])
      2'b00: flen = `TPG_LEN_00;
      2'b01: flen = `TPG_LEN_01;
      2'b10: flen = `TPG_LEN_10;
      2'b11: flen = `TPG_LEN_11;
    endcase
  end

  assign plen = flen - `TPG_OVH_BYTES;
  assign fcs = cfg_reg[`TPG_B_BADFCS] ? crc_reg : ~crc_reg;

  always_comb begin
    byte_cur = 8'hff;
    unique case (state_reg)
      ST_HDR: begin
        if (bcnt_reg == 14'd5) begin
          byte_cur = {4'hf, cfg_reg[`TPG_B_DA_H:`TPG_B_DA_L]};
        end else if (bcnt_reg == 14'd11) begin
          byte_cur = {4'hf, cfg_reg[`TPG_B_SA_H:`TPG_B_SA_L]};
        end else if (bcnt_reg == 14'd12) begin
          byte_cur = {2'b00, plen[13:8]};
        end else if (bcnt_reg == 14'd13) begin
          byte_cur = plen[7:0];
        end
      end
      ST_PAY: begin
        if (cfg_reg[`TPG_B_RAND]) begin
          byte_cur = lfsr_reg[7:0];
        end else begin
          byte_cur = bcnt_reg[0] ? pat_reg[7:0] : pat_reg[15:8];
        end
      end
      ST_FCS: byte_cur = fcs[8*bcnt_reg[1:0] +: 8];
      default: byte_cur = 8'hff;
    endcase
  end

  assign push = (state_reg == ST_HDR || state_reg == ST_PAY || state_reg == ST_FCS) && in_ready;
  assign frame_end = push && state_reg == ST_FCS && bcnt_reg == 14'd3;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      crc_reg <= `TPG_CRC_INIT;
    end else if (state_reg == ST_GAP || state_reg == ST_IDLE) begin
      crc_reg <= `TPG_CRC_INIT;
    end else if (push && state_reg != ST_FCS) begin
      crc_reg <= crc_step(crc_reg, byte_cur);
    end
  end

  // Random payload keeps running across frames so frames differ
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lfsr_reg <= `TPG_LFSR_SEED;
    end else if (take) begin
      lfsr_reg <= `TPG_LFSR_SEED;
    end else if (push && state_reg == ST_PAY) begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[14] ^ lfsr_reg[12] ^ lfsr_reg[3]};
    end
  end

  // ==========
  // Packet counting
  always_comb begin
    if (!go) begin
      stop = 1'b1;
    end else if (cfg_reg[`TPG_B_CONT]) begin
      stop = !ctrl_reg[`TPG_B_CONT] && blk_reg == 14'(BLOCK_PKTS - 1);
    end else begin
      stop = tot_reg == 25'(RUN_PKTS - 1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      blk_reg <= '0;
      tot_reg <= '0;
    end else if (take) begin
      blk_reg <= '0;
      tot_reg <= '0;
    end else if (frame_end) begin
      blk_reg <= (blk_reg == 14'(BLOCK_PKTS - 1)) ? '0 : blk_reg + 14'd1;
      tot_reg <= tot_reg + 25'd1;
    end
  end

  // ==========
  // Sequencer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      bcnt_reg <= '0;
      gap_reg <= '0;
    end else if (take) begin
      state_reg <= ST_HDR;
      bcnt_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: bcnt_reg <= '0;
        ST_HDR: begin
          if (push) begin
            bcnt_reg <= (bcnt_reg == `TPG_HDR_BYTES - 14'd1) ? '0 : bcnt_reg + 14'd1;
            if (bcnt_reg == `TPG_HDR_BYTES - 14'd1) begin
              state_reg <= ST_PAY;
            end
          end
        end
        ST_PAY: begin
          if (push) begin
            bcnt_reg <= (bcnt_reg == plen - 14'd1) ? '0 : bcnt_reg + 14'd1;
            if (bcnt_reg == plen - 14'd1) begin
              state_reg <= ST_FCS;
            end
          end
        end
        ST_FCS: begin
          if (push) begin
            bcnt_reg <= bcnt_reg + 14'd1;
          end
          if (frame_end) begin
            bcnt_reg <= '0;
            state_reg <= stop ? ST_IDLE : ST_GAP;
            gap_reg <= cfg_reg[`TPG_B_GAP] ? 10'(GAP_L - 1) : 10'(GAP_S - 1);
          end
        end
        ST_GAP: begin
          if (!go) begin
            state_reg <= ST_IDLE;
          end else if (gap_reg == '0) begin
            state_reg <= ST_HDR;
          end else begin
            gap_reg <= gap_reg - 10'd1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= state_reg != ST_IDLE;
    end
  end

  // ==========
  // Output FIFO and register stage
  tpg_fifo #(.W(9), .D(`TPG_FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_data_i({frame_end, byte_cur}),
    .in_valid_i(state_reg == ST_HDR || state_reg == ST_PAY || state_reg == ST_FCS),
    .in_ready_o(in_ready),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(!tx_valid_o || tx_ready_i)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o <= '0;
      tx_last_o <= 1'b0;
    end else if (!tx_valid_o || tx_ready_i) begin
      tx_valid_o <= fifo_valid;
      tx_data_o <= fifo_data[7:0];
      tx_last_o <= fifo_data[8];
    end
  end
endmodule
`default_nettype wire

// [sim/tpg_gen_sva.sv]
// Concurrent checks on the packet generator ports
`timescale 1ns/1ns
`default_nettype none
`include "tpg_cfg.svh"
module tpg_gen_sva #(
  parameter int unsigned BLOCK_PKTS = 4,
  parameter int unsigned RUN_PKTS = 6
) (
  // Clock, reset, registers
  input wire logic clk_i,
  input wire logic rst_i,
  input wire tpg_pkg::tpg_addr_t reg_addr_i,
  input wire tpg_pkg::tpg_word_t reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire tpg_pkg::tpg_word_t reg_rdata_o,
  // Streams
  input wire logic rx_crc_err_i,
  input wire tpg_pkg::tpg_byte_t tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic busy_o
);
  import tpg_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  tpg_word_t ctrl_reg;
  logic [1:0] len_reg;
  logic busy_q_reg;
  logic [13:0] cnt_reg;
  // ==========
  // Shadow state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= `TPG_CTRL_RST;
    end else if (reg_we_i && reg_addr_i == `TPG_ADDR_CTRL) begin
      ctrl_reg <= reg_wdata_i;
    end
  end
  // Length is taken when the sequencer wakes, as the design latches it at start
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q_reg <= 1'b0;
      len_reg <= 2'b00;
    end else begin
      busy_q_reg <= busy_o;
      if (busy_o && !busy_q_reg) begin
        len_reg <= ctrl_reg[12:11];
      end
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 14'h0;
    end else if (tx_valid_o && tx_ready_i) begin
      cnt_reg <= tx_last_o ? 14'h0 : cnt_reg + 14'h1;
    end
  end
  function automatic logic [13:0] flen(input logic [1:0] c);
    return c == 2'b00 ? `TPG_LEN_00 : c == 2'b01 ? `TPG_LEN_01 :
      c == 2'b10 ? `TPG_LEN_10 : `TPG_LEN_11;
  endfunction
  // ==========
  // Assertions
  sequence s_wr(a);
    reg_we_i && reg_addr_i == a;
  endsequence
  sequence s_rd(a);
    reg_re_i && !reg_we_i && reg_addr_i == a;
  endsequence
  a_ctrl_readback: assert property (
    s_wr(`TPG_ADDR_CTRL) ##1 s_rd(`TPG_ADDR_CTRL) |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("control readback differs");
  a_pattern_readback: assert property (
    s_wr(`TPG_ADDR_PAY) ##1 s_rd(`TPG_ADDR_PAY) |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("pattern readback differs");
  a_count_high_zero: assert property (
    s_rd(`TPG_ADDR_CRC) |=> reg_rdata_o[15:8] == 8'h00)
    else $error("count upper byte not zero");
  a_stall_hold: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
    else $error("byte changed while stalled");
  a_frame_length: assert property (
    tx_valid_o && tx_ready_i && tx_last_o |-> cnt_reg == flen(len_reg) - 14'd1)
    else $error("frame length wrong");
  a_dest_first: assert property (
    tx_valid_o && cnt_reg == 14'd0 |-> tx_data_o == 8'hff)
    else $error("first address byte wrong");
  a_source_low: assert property (
    tx_valid_o && cnt_reg == 14'd11 |-> tx_data_o[7:4] == 4'hf)
    else $error("source address upper nibble wrong");
  a_start_gate: assert property (
    $rose(busy_o) |-> ctrl_reg[15] && ctrl_reg[14])
    else $error("started without enable and run");
  a_valid_busy: assert property (
    $rose(tx_valid_o) |-> busy_o || $past(busy_o))
    else $error("byte sent while idle");
endmodule
bind tpg_gen tpg_gen_sva #(.BLOCK_PKTS(BLOCK_PKTS), .RUN_PKTS(RUN_PKTS)) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
  .rx_crc_err_i(rx_crc_err_i), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
  .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i), .busy_o(busy_o));
`default_nettype wire

// [sim/tpg_sink.sv]
// Link partner model: takes frames, checks FCS, reports receive CRC errors
`timescale 1ns/1ns
`default_nettype none
`include "tpg_cfg.svh"
module tpg_sink (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Stream and controls
  input wire tpg_pkg::tpg_byte_t data_i,
  input wire logic valid_i,
  input wire logic last_i,
  input wire logic stall_i,
  input wire logic inj_i,
  output logic ready_o,
  output logic crc_err_o
);
  import tpg_pkg::*;
  logic [31:0] crc;
  logic fcs_ok;
  logic err;
  int n, len, frames, gap, idle;
  tpg_byte_t mem [0:10015];
  function automatic logic [31:0] crc_step(input logic [31:0] c, input tpg_byte_t b);
    c = c ^ {24'h0, b};
    for (int k = 0; k < 8; k++) begin
      c = c[0] ? (c >> 1) ^ `TPG_CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  // ==========
  // Receiver
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
      crc_err_o <= 1'b0;
      n = 0;
      frames = 0;
      idle = 0;
      crc = `TPG_CRC_INIT;
    end else begin
      err = inj_i;
      ready_o <= !stall_i || ($urandom_range(3) != 0);
      if (valid_i && ready_o) begin
        if (n == 0) begin
          gap = idle;
        end
        mem[n] = data_i;
        crc = crc_step(crc, data_i);
        n++;
        if (last_i) begin
          // A good FCS leaves the fixed residue in the register
          fcs_ok = (crc == 32'hdebb20e3);
          err = inj_i || !fcs_ok;
          len = n;
          n = 0;
          frames++;
          crc = `TPG_CRC_INIT;
        end
      end
      idle = valid_i ? 0 : idle + 1;
      // One update per edge, so the error pulse is never driven twice
      crc_err_o <= err;
    end
  end
endmodule
`default_nettype wire

// [sim/tpg_gen_tb.sv]
// Self-checking bench of the packet generator
`timescale 1ns/1ns
`default_nettype none
`include "tpg_cfg.svh"
module tpg_gen_tb;
  import tpg_pkg::*;
  localparam int BLK = 4;
  localparam int RUN = 6;
  logic clk_i = 0, rst_i = 1, reg_we_i = 0, reg_re_i = 0, stall = 0, inj = 0;
  logic tx_valid_o, tx_last_o, tx_ready_i, busy_o, rx_crc_err_i;
  tpg_addr_t reg_addr_i = 5'h00;
  tpg_word_t reg_wdata_i = 16'h0000, reg_rdata_o, d, pat, cw;
  tpg_byte_t tx_data_o;
  logic [3:0] da, sa;
  int fail_count = 0, n_checks = 0, base;
  always #5 clk_i = ~clk_i;
  tpg_gen #(.BLOCK_PKTS(BLK), .RUN_PKTS(RUN)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .rx_crc_err_i(rx_crc_err_i),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o),
    .tx_ready_i(tx_ready_i), .busy_o(busy_o));
  tpg_sink LP (.clk_i(clk_i), .rst_i(rst_i), .data_i(tx_data_o), .valid_i(tx_valid_o),
    .last_i(tx_last_o), .stall_i(stall), .inj_i(inj), .ready_o(tx_ready_i),
    .crc_err_o(rx_crc_err_i));
  // ==========
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input tpg_addr_t a, input tpg_word_t v);
    reg_addr_i = a;
    reg_wdata_i = v;
    reg_we_i = 1;
    @(negedge clk_i);
    reg_we_i = 0;
  endtask
  task automatic rd(input tpg_addr_t a, output tpg_word_t v);
    reg_addr_i = a;
    reg_re_i = 1;
    @(negedge clk_i);
    reg_re_i = 0;
    v = reg_rdata_o;
  endtask
  // Bounded wait for a frame count, then past the longest gap
  task automatic run_wait(input int want);
    int k;
    k = 0;
    while (LP.frames < want && k < 60000) begin
      @(negedge clk_i);
      k++;
    end
    if (k == 60000) begin
      fail_count++;
      print_verdict();
    end
    repeat (900) @(negedge clk_i);
  endtask
  function automatic int flen(input int c);
    return c == 0 ? 125 : c == 1 ? 64 : c == 2 ? 1518 : 10000;
  endfunction
  // Iteration i picks length i; gap on 0, bad FCS on 1, random on 2, continuous on 3
  function automatic tpg_word_t ctrl_word(input int i, input logic [3:0] a, input logic [3:0] b);
    return {2'b11, i == 3, 2'(i), i == 0, a, b, i == 2, i == 1};
  endfunction
  // ==========
  // Main sequence
  initial begin
    void'($urandom(50172));
    repeat (10) @(negedge clk_i);
    rst_i = 0;
    rd(`TPG_ADDR_CTRL, d);
    check(d, 16'h0040);
    rd(`TPG_ADDR_PAY, d);
    check(d, 16'h0000);
    rd(5'h05, d);
    check(d, 16'h0000);
    wr(`TPG_ADDR_CTRL, 16'h4000);
    repeat (50) @(negedge clk_i);
    check(busy_o, 0);
    check(LP.frames, 0);
    wr(`TPG_ADDR_CTRL, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      pat = 16'($urandom);
      da = 4'($urandom);
      sa = 4'($urandom);
      cw = ctrl_word(i, da, sa);
      stall = (i != 0);
      wr(`TPG_ADDR_PAY, pat);
      rd(`TPG_ADDR_PAY, d);
      wr(`TPG_ADDR_CTRL, cw);
      rd(`TPG_ADDR_CTRL, d);
      base = LP.frames;
      if (i == 0 || i == 3) begin
        run_wait(base + 1);
        wr(`TPG_ADDR_PAY, ~pat);
        wr(`TPG_ADDR_CTRL, i == 0 ? cw ^ 16'h03c0 : cw & 16'hdfff);
      end
      run_wait(base + (i == 3 ? BLK : RUN));
      check(LP.frames - base, i == 3 ? BLK : RUN);
      check(busy_o, 0);
      check(LP.len, flen(i));
      check(LP.mem[5], {4'hf, da});
      check(LP.mem[11], {4'hf, sa});
      check({LP.mem[12], LP.mem[13]}, flen(i) - 18);
      if (i != 2) begin
        check({LP.mem[14], LP.mem[15], LP.mem[16], LP.mem[17]}, {pat, pat});
      end else begin
        check({LP.mem[14], LP.mem[15], LP.mem[16]} == {pat, pat[15:8]}, 0);
      end
      check(LP.fcs_ok, i != 1);
      check(i == 0 ? LP.gap > 780 && LP.gap < 840 : LP.gap < 40, 1);
      rd(`TPG_ADDR_CRC, d);
      check(d, i == 1 ? RUN : 0);
      wr(`TPG_ADDR_CTRL, cw & 16'hbfff);
    end
    repeat (300) begin
      inj = 1;
      @(negedge clk_i);
      inj = 0;
      @(negedge clk_i);
    end
    rd(`TPG_ADDR_CRC, d);
    check(d, 16'h00ff);
    rd(`TPG_ADDR_CRC, d);
    check(d, 16'h0000);
    print_verdict();
  end
endmodule
`default_nettype wire
